// [logic/sgac_regs.v]
/*
 Register bank of the serial gigabit port PCS: partner base page,
 page-received latch, autoneg complete, PCS mode and digital control.
 Assumes a classic Wishbone master on mclk and an autoneg engine
 that delivers partner pages and completion as one-cycle pulses.

 // Summary of operation
 // R1: On autoneg completion the partner base page is captured read-only.
 // R2: Partner fields are meaningful only in 1000BASE-X mode; SGMII uses its status.
 // R3: Bit 15 shows partner next-page ability and no next page is ever sent.
 // R4: Bit 14 shows the partner acknowledge of our page.
 // R5: Bits 13:12 show partner fault: none, offline, link failure, autoneg error.
 // R6: Bits 8:7 show partner pause: none, asym, sym, sym plus asym.
 // R7: Bits 6 and 5 show partner half and full duplex and reset to zero.
 // R8: Expansion bit 1 latches on a received page and clears when read.
 // R9: Control bit 14 loops received serial data back to the serial output.
 // R10: The loopback is done digitally in the PCS.
 // R11: Control bit 11 powers down receiver and transmitter, PLL stays on.
 // R12: Autoneg complete asserts once acknowledge codewords are exchanged.
 // R13: Mode field 00 selects 1000BASE-X and 10 selects SGMII autoneg.
 // R14: Software updates the digital control register read-modify-write.
*/
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`include "sgac_map.vh"

module sgac_regs #(
    parameter SYM_W = `SGAC_SYM_W
) (
    input wire mclk,
    input wire rst_b,
    input wire [`SGAC_ADR_W-1:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire anPageValid,
    input wire [15:0] anPageWord,
    input wire anAckDone,
    input wire anRestart,
    input wire [SYM_W-1:0] rxSymbol,
    input wire [SYM_W-1:0] txSymbol,
    output wire [SYM_W-1:0] serTxSymbol,
    output wire [SYM_W-1:0] coreRxSymbol,
    output wire rxPowerDown,
    output wire txPowerDown,
    output wire pllPowerDown,
    output reg anComplete,
    output reg sgmiiMode,
    output reg localNextPage,
    output reg partnerValid,
    output reg [1:0] partnerFault,
    output reg [1:0] partnerPause,
    output reg partnerHalfDuplex,
    output reg partnerFullDuplex
);

    localparam ST_IDLE = 2'b01;
    localparam ST_ACK = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;

    reg [15:0] partnerAbility;
    reg [15:0] pageStage;
    reg pageReceived;
    reg [15:0] digitalControl;
    reg [15:0] anControl;

    wire [`SGAC_IDX_W-1:0] regIndex;
    wire request;
    wire take;
    wire writeTake;
    wire readTake;
    wire hitPartner;
    wire hitExpan;
    wire hitDctrl;
    wire hitAnctrl;
    wire hitStatus;
    wire [1:0] modeField;
    wire [15:0] freshPage;
    wire [15:0] dctrlWrite;
    wire [15:0] anctrlWrite;
    wire mode1000x;
    wire modeSgmii;
    wire decodeOn;
    wire expanReadClear;
    wire [15:0] expanView;
    wire [15:0] statusView;

    reg [15:0] readValue;

    assign regIndex = wb_adr_i[`SGAC_ADR_W-1:2];
    assign request = wb_cyc_i & wb_stb_i;
    assign take = request & state[0];
    assign writeTake = take & wb_we_i;
    assign readTake = take & ~wb_we_i;

    assign hitPartner = (regIndex == `SGAC_IDX_PARTNER);
    assign hitExpan = (regIndex == `SGAC_IDX_EXPAN);
    assign hitDctrl = (regIndex == `SGAC_IDX_DCTRL);
    assign hitAnctrl = (regIndex == `SGAC_IDX_ANCTRL);
    assign hitStatus = (regIndex == `SGAC_IDX_STATUS);

    assign modeField = anControl[`SGAC_MODE_HI:`SGAC_MODE_LO];

    // Reserved mode codes decode to neither mode, see R13
    assign mode1000x = (modeField == `SGAC_MODE_1000X);
    assign modeSgmii = (modeField == `SGAC_MODE_SGMII);

    // Partner fields decoded only after completion in 1000BASE-X, see R2
    assign decodeOn = anComplete & mode1000x;

    // Reading the expansion register clears the page latch, see R8
    assign expanReadClear = readTake & hitExpan;

    // Register views with their fixed bits
    assign expanView = {15'h0000, pageReceived} << `SGAC_PAGE_RX_BIT;
    assign statusView = `SGAC_STATUS_FIXED | ({15'h0000, anComplete} << `SGAC_AN_DONE_BIT);

    // Page arriving with completion wins over the staged one
    assign freshPage = anPageValid ? anPageWord : pageStage;

    // Byte lanes of the write data, low two lanes only
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane = lane + 1) begin : gLane
            assign dctrlWrite[lane*8+7:lane*8] = wb_sel_i[lane]
                ? wb_dat_i[lane*8+7:lane*8]
                : digitalControl[lane*8+7:lane*8];
            assign anctrlWrite[lane*8+7:lane*8] = wb_sel_i[lane]
                ? wb_dat_i[lane*8+7:lane*8]
                : anControl[lane*8+7:lane*8];
        end
    endgenerate

    // Bus handshake: ack one cycle after the request, then drop
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (request) begin
                    next_state = ST_ACK;
                end
            end
            ST_ACK: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Ack only for a request taken while idle, so never two in a row
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= take;
        end
    end

    // Read multiplexer, unmapped indices read zero
    always @* begin
        readValue = 16'h0000;
        if (hitPartner) begin
            readValue = partnerAbility;
        end else if (hitExpan) begin
            readValue = expanView; // see R8
        end else if (hitDctrl) begin
            readValue = digitalControl;
        end else if (hitAnctrl) begin
            readValue = anControl;
        end else if (hitStatus) begin
            readValue = statusView; // see R12
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h00000000;
        end else if (readTake) begin
            wb_dat_o <= {16'h0000, readValue};
        end else begin
            wb_dat_o <= 32'h00000000;
        end
    end

    // Digital control, every bit read-write
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            digitalControl <= `SGAC_DCTRL_RESET;
        end else if (writeTake && hitDctrl) begin
            // Reserved fields kept only if software preserves them, see R14
            digitalControl <= dctrlWrite;
        end
    end

    // Autoneg control, only the low five bits are writable
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            anControl <= `SGAC_ANCTRL_RESET;
        end else if (writeTake && hitAnctrl) begin
            anControl <= anctrlWrite & `SGAC_ANCTRL_MASK;
        end
    end

    // Last page from the partner, held until completion
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pageStage <= 16'h0000;
        end else if (anPageValid) begin
            pageStage <= anPageWord;
        end
    end

    // Page received latch: set beats the read clear, see R8
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pageReceived <= 1'b0;
        end else if (anPageValid) begin
            pageReceived <= 1'b1;
        end else if (expanReadClear) begin
            pageReceived <= 1'b0;
        end
    end

    // Completion status
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            anComplete <= 1'b0;
        end else if (anAckDone) begin
            // Completion beats a restart in the same cycle
            anComplete <= 1'b1; // see R12
        end else if (anRestart) begin
            anComplete <= 1'b0;
        end
    end

    // Base page capture on completion, kept across a restart
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            partnerAbility <= 16'h0000; // see R7
        end else if (anAckDone) begin
            // Reserved bits forced to zero, see R1 see R4
            partnerAbility <= freshPage & `SGAC_PARTNER_MASK;
        end
    end

    // Mode flag for the MAC
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sgmiiMode <= 1'b1;
        end else begin
            sgmiiMode <= modeSgmii; // see R13
        end
    end

    // Next page never sent, whatever the partner offers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            localNextPage <= 1'b0;
        end else begin
            localNextPage <= 1'b0; // see R3
        end
    end

    // Fields valid only for 1000BASE-X
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            partnerValid <= 1'b0;
        end else begin
            partnerValid <= decodeOn; // see R2 see R13
        end
    end

    // Partner fault code
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            partnerFault <= 2'h0;
        end else if (decodeOn) begin
            partnerFault <= partnerAbility[`SGAC_RF_HI:`SGAC_RF_LO]; // see R5
        end else begin
            partnerFault <= 2'h0;
        end
    end

    // Partner pause code
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            partnerPause <= 2'h0;
        end else if (decodeOn) begin
            partnerPause <= partnerAbility[`SGAC_PAUSE_HI:`SGAC_PAUSE_LO]; // see R6
        end else begin
            partnerPause <= 2'h0;
        end
    end

    // Partner duplex abilities
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            partnerHalfDuplex <= 1'b0;
            partnerFullDuplex <= 1'b0;
        end else if (decodeOn) begin
            partnerHalfDuplex <= partnerAbility[`SGAC_HD_BIT]; // see R7
            partnerFullDuplex <= partnerAbility[`SGAC_FD_BIT]; // see R7
        end else begin
            partnerHalfDuplex <= 1'b0;
            partnerFullDuplex <= 1'b0;
        end
    end

    // Partner next-page and acknowledge bits are readable as captured
    // at bits 15 and 14 of the partner register, see R3 see R4

    sgac_pcs_loop #(
        .SYM_W(SYM_W)
    ) uPcsLoop (
        .mclk(mclk),
        .rst_b(rst_b),
        .loopEnable(digitalControl[`SGAC_LOOP_BIT]), // see R9
        .powerSave(digitalControl[`SGAC_PSAVE_BIT]), // see R11
        .rxSymbol(rxSymbol),
        .txSymbol(txSymbol),
        .serTxSymbol(serTxSymbol),
        .coreRxSymbol(coreRxSymbol),
        .rxPowerDown(rxPowerDown),
        .txPowerDown(txPowerDown),
        .pllPowerDown(pllPowerDown)
    );

endmodule

// [logic/sgac_map.vh]
/*
 Register indices, field positions, reset values and fixed codes
 of the serial port autoneg status and control bank.
 Assumes a Wishbone slave with 32-bit data: byte address = 4 * index.
*/
`ifndef SGAC_MAP_VH
`define SGAC_MAP_VH

`define SGAC_ADR_W 24
`define SGAC_IDX_W 22
`define SGAC_IDX_STATUS 22'h1f0001
`define SGAC_IDX_PARTNER 22'h1f0005
`define SGAC_IDX_EXPAN 22'h1f0006
`define SGAC_IDX_DCTRL 22'h1f8000
`define SGAC_IDX_ANCTRL 22'h1f8001

`define SGAC_NP_BIT 15
`define SGAC_ACK_BIT 14
`define SGAC_RF_HI 13
`define SGAC_RF_LO 12
`define SGAC_PAUSE_HI 8
`define SGAC_PAUSE_LO 7
`define SGAC_HD_BIT 6
`define SGAC_FD_BIT 5
`define SGAC_PARTNER_MASK 16'hf1e0

`define SGAC_PAGE_RX_BIT 1

`define SGAC_LOOP_BIT 14
`define SGAC_PSAVE_BIT 11
`define SGAC_DCTRL_RESET 16'h2400

`define SGAC_MODE_HI 2
`define SGAC_MODE_LO 1
`define SGAC_ANCTRL_MASK 16'h001f
`define SGAC_ANCTRL_RESET 16'h0004
`define SGAC_MODE_1000X 2'h0
`define SGAC_MODE_SGMII 2'h2

`define SGAC_AN_DONE_BIT 5
`define SGAC_STATUS_FIXED 16'h0189

`define SGAC_SYM_W 10
`define SGAC_IDLE_SYM 10'h000

`endif

// [logic/sgac_pcs_loop.v]
/*
 PCS code-group path of the serial port: digital remote loopback
 and power-save gating of receiver and transmitter.
 Assumes code groups are synchronous to mclk, one per cycle.
*/
`timescale 1ns/10ps
`include "sgac_map.vh"

module sgac_pcs_loop #(
    parameter SYM_W = `SGAC_SYM_W
) (
    input wire mclk,
    input wire rst_b,
    input wire loopEnable,
    input wire powerSave,
    input wire [SYM_W-1:0] rxSymbol,
    input wire [SYM_W-1:0] txSymbol,
    output reg [SYM_W-1:0] serTxSymbol,
    output reg [SYM_W-1:0] coreRxSymbol,
    output reg rxPowerDown,
    output reg txPowerDown,
    output reg pllPowerDown
);

    reg [SYM_W-1:0] next_serTxSymbol;
    reg [SYM_W-1:0] next_coreRxSymbol;

    always @* begin
        next_serTxSymbol = txSymbol;
        next_coreRxSymbol = rxSymbol;
        if (loopEnable) begin
            // Received groups go back out, see R9 see R10
            next_serTxSymbol = rxSymbol;
        end
        if (powerSave) begin
            // Lanes quiet while powered down, see R11
            next_serTxSymbol = `SGAC_IDLE_SYM;
            next_coreRxSymbol = `SGAC_IDLE_SYM;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            serTxSymbol <= `SGAC_IDLE_SYM;
            coreRxSymbol <= `SGAC_IDLE_SYM;
            rxPowerDown <= 1'b0;
            txPowerDown <= 1'b0;
            pllPowerDown <= 1'b0;
        end else begin
            serTxSymbol <= next_serTxSymbol;
            coreRxSymbol <= next_coreRxSymbol;
            rxPowerDown <= powerSave; // see R11
            txPowerDown <= powerSave; // see R11
            // PLL stays on in power save, see R11
            pllPowerDown <= 1'b0;
        end
    end

endmodule

// [dv/sgac_regs_asserts.sv]
/* Port checker for sgac_regs.
 Assumes binding onto each sgac_regs instance. */
`timescale 1ns/10ps
module sgac_regs_chk #(parameter SYM_W = 10) (
    input wire mclk,
    input wire rst_b,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire anAckDone,
    input wire anRestart,
    input wire [SYM_W-1:0] rxSymbol,
    input wire [SYM_W-1:0] coreRxSymbol,
    input wire rxPowerDown,
    input wire txPowerDown,
    input wire pllPowerDown,
    input wire anComplete,
    input wire sgmiiMode,
    input wire localNextPage,
    input wire partnerValid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_done;
        anComplete ##1 (partnerValid || sgmiiMode);
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
    a_pll_on: assert property (!pllPowerDown) else $error("pll off");
    a_pd_pair: assert property (rxPowerDown == txPowerDown) else $error("pd pair");
    a_no_nextpage: assert property (!localNextPage) else $error("next page");
    a_an_done: assert property (anAckDone |=> s_done) else $error("no complete");
    a_an_restart: assert property (anRestart && !anAckDone |=> !anComplete)
        else $error("restart kept complete");
    a_rx_path: assert property (!rxPowerDown && $past(rst_b) |->
        coreRxSymbol == $past(rxSymbol)) else $error("rx path");
    a_sgmii_gate: assert property (sgmiiMode && $past(sgmiiMode) |-> !partnerValid)
        else $error("partner valid in sgmii");
endmodule
bind sgac_regs sgac_regs_chk #(.SYM_W(SYM_W)) u_chk (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .anAckDone, .anRestart, .rxSymbol, .coreRxSymbol, .rxPowerDown,
    .txPowerDown, .pllPowerDown, .anComplete, .sgmiiMode, .localNextPage, .partnerValid);

// [dv/sgac_link_partner.sv]
/* Link partner model: autoneg page events and received code groups.
 Assumes tasks are called by the bench on mclk. */
`timescale 1ns/10ps
module sgac_link_partner #(parameter SYM_W = 10) (
    input wire mclk,
    output reg anPageValid,
    output reg [15:0] anPageWord,
    output reg anAckDone,
    output reg anRestart,
    output reg [SYM_W-1:0] rxSymbol
);
    initial begin
        anPageValid = 1'b0;
        anPageWord = 16'h0;
        anAckDone = 1'b0;
        anRestart = 1'b0;
        rxSymbol = 10'h0;
    end
    // Code groups change every cycle
    always @(posedge mclk) begin
        rxSymbol <= rxSymbol + 10'h133;
    end
    // Page carries partner abilities and its ack of our page
    task send_page(input [15:0] w);
        @(posedge mclk);
        anPageValid <= 1'b1;
        anPageWord <= w;
        @(posedge mclk);
        anPageValid <= 1'b0;
        anPageWord <= ~w;
    endtask
    task pulse(input r);
        @(posedge mclk);
        if (r) anRestart <= 1'b1; else anAckDone <= 1'b1;
        @(posedge mclk);
        anRestart <= 1'b0;
        anAckDone <= 1'b0;
    endtask
endmodule

// [dv/serdes_autoneg_status_ctrl_tb_top.sv]
/* Self-checking bench for sgac_regs.
 Assumes the partner model drives the link side. */
`timescale 1ns/10ps
`include "sgac_map.vh"
module serdes_autoneg_status_ctrl_tb_top;
    reg mclk = 1'b0;
    reg rst_b = 1'b0;
    reg [23:0] wb_adr_i = 24'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg [3:0] wb_sel_i = 4'h0;
    reg wb_we_i = 1'b0;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg [9:0] txSymbol = 10'h0;
    wire [31:0] wb_dat_o;
    wire [15:0] anPageWord;
    wire [9:0] rxSymbol, serTxSymbol, coreRxSymbol;
    wire [1:0] partnerFault, partnerPause;
    wire wb_ack_o, anPageValid, anAckDone, anRestart, rxPowerDown, txPowerDown;
    wire pllPowerDown, anComplete, sgmiiMode, localNextPage, partnerValid;
    wire partnerHalfDuplex, partnerFullDuplex;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 72837;
    int i;
    reg [15:0] dctrl = 16'h2400;
    reg [15:0] q, w, s;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) txSymbol <= 10'($random(seed));
    sgac_link_partner u_sgac_link_partner (.mclk, .anPageValid, .anPageWord, .anAckDone,
        .anRestart, .rxSymbol);
    sgac_regs u_sgac_regs (.mclk, .rst_b, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .anPageValid, .anPageWord, .anAckDone,
        .anRestart, .rxSymbol, .txSymbol, .serTxSymbol, .coreRxSymbol, .rxPowerDown,
        .txPowerDown, .pllPowerDown, .anComplete, .sgmiiMode, .localNextPage, .partnerValid,
        .partnerFault, .partnerPause, .partnerHalfDuplex, .partnerFullDuplex);
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input [21:0] idx, input wr, input [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wb_adr_i <= {idx, 2'b00};
        wb_we_i <= wr;
        wb_dat_i <= {16'h0, d};
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) chk(0, 1);
    endtask
    task rd(input [21:0] idx, input [15:0] e);
        bus(idx, 1'b0, 16'h0);
        chk(q, e);
    endtask
    task sym(input lb);
        repeat (8) begin
            @(posedge mclk);
            #1 s = lb ? rxSymbol : txSymbol;
            @(posedge mclk);
            #1 chk(serTxSymbol, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd(`SGAC_IDX_DCTRL, dctrl);
        rd(`SGAC_IDX_EXPAN, 16'h0);
        bus(`SGAC_IDX_PARTNER, 1'b1, 16'hffff);
        rd(`SGAC_IDX_PARTNER, 16'h0);
        bus(22'h1f8004, 1'b1, 16'hffff);
        rd(22'h1f8004, 16'h0);
        chk(sgmiiMode, 1);
        $display("test reset done");
        bus(`SGAC_IDX_ANCTRL, 1'b1, 16'h0);
        for (i = 0; i < 4; i++) begin
            w = 16'($random(seed));
            w[13:12] = 2'(i);
            w[8:7] = 2'(3 - i);
            u_sgac_link_partner.send_page(w);
            rd(`SGAC_IDX_EXPAN, 16'h2);
            rd(`SGAC_IDX_EXPAN, 16'h0);
            u_sgac_link_partner.pulse(1'b0);
            rd(`SGAC_IDX_PARTNER, w & `SGAC_PARTNER_MASK);
            chk({partnerValid, partnerFault, partnerPause, partnerHalfDuplex,
                partnerFullDuplex}, {1'b1, w[13:12], w[8:7], w[6], w[5]});
            rd(`SGAC_IDX_STATUS, 16'h01a9);
        end
        u_sgac_link_partner.pulse(1'b1);
        rd(`SGAC_IDX_STATUS, 16'h0189);
        $display("test pages done");
        bus(`SGAC_IDX_ANCTRL, 1'b1, 16'h4);
        u_sgac_link_partner.send_page(16'hffff);
        u_sgac_link_partner.pulse(1'b0);
        rd(`SGAC_IDX_PARTNER, 16'hf1e0);
        chk({sgmiiMode, partnerValid, partnerFault}, 4'h8);
        $display("test sgmii done");
        sym(1'b0);
        bus(`SGAC_IDX_DCTRL, 1'b0, 16'h0);
        dctrl = q | 16'h4000;
        bus(`SGAC_IDX_DCTRL, 1'b1, dctrl);
        rd(`SGAC_IDX_DCTRL, dctrl);
        sym(1'b1);
        dctrl = dctrl | 16'h0800;
        bus(`SGAC_IDX_DCTRL, 1'b1, dctrl);
        repeat (2) @(posedge mclk);
        #1 chk({rxPowerDown, txPowerDown, pllPowerDown, serTxSymbol, coreRxSymbol},
            23'h600000);
        bus(`SGAC_IDX_DCTRL, 1'b1, 16'h2400);
        sym(1'b0);
        $display("test datapath done");
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        tally_and_finish;
    end
endmodule
